//--- src/otpsec_defs.svh
/*
  Offsets, field positions, reset values and port identifiers for the
  one-time-programmable store and its security configuration register.
  Assumes inclusion by bare name from files under src/ and test/.
*/
`ifndef OTPSEC_DEFS_SVH
`define OTPSEC_DEFS_SVH

// ==========================================================
// Store organisation
`define OTPSEC_SECTORS        4
`define OTPSEC_ROWS           512
`define OTPSEC_WORD_W         32
`define OTPSEC_CFG_ROW        13'h1fff

// ==========================================================
// I/O port resource identifiers
`define OTPSEC_RID_ADDR       24'h100200
`define OTPSEC_RID_DATA       24'h200100
`define OTPSEC_RID_CTRL       24'h100300

// ==========================================================
// Security configuration bit positions
`define OTPSEC_B_NO_JTAG      0
`define OTPSEC_B_NO_LINK      1
`define OTPSEC_B_SEC_BOOT     5
`define OTPSEC_B_REDUND       7
`define OTPSEC_B_SLOCK0       8
`define OTPSEC_B_MLOCK        12
`define OTPSEC_B_NO_JTAG_OTP  13
`define OTPSEC_B_NO_DBG_SYNC  14
`define OTPSEC_GP_LO          15
`define OTPSEC_GP_HI          21
`define OTPSEC_UC_LO          22
`define OTPSEC_UC_HI          31
`define OTPSEC_STICKY_MASK    32'h0000_7f23

// ==========================================================
// Control port fields
`define OTPSEC_CTL_PROG       0
`define OTPSEC_CTL_CFG        1
`define OTPSEC_CTL_READ       2

// ==========================================================
// Reset values
`define OTPSEC_CFG_RESET      32'h0000_0000

`endif

//--- src/otpsec_pkg.sv
/*
  Types shared by the security-control block.
  Assumes otpsec_defs.svh sits beside it.
*/
package otpsec_pkg;

  typedef enum logic [1:0] {
    OTPSEC_LOAD_CFG  = 2'b00,
    OTPSEC_COPY_BOOT = 2'b01,
    OTPSEC_RUN       = 2'b11
  } otpsec_state_t;

  typedef struct packed {
    logic        wr;
    logic [23:0] rid;
    logic [31:0] data;
  } otpsec_io_t;

  typedef struct packed {
    logic        no_jtag;
    logic        no_link;
    logic        sec_boot;
    logic        redund;
    logic        no_jtag_otp;
    logic        no_dbg_sync;
    logic [6:0]  gp_field;
    logic [9:0]  user_code;
  } otpsec_gate_t;

endpackage : otpsec_pkg

//--- src/otpsec_ctrl.sv
/*
  Security control for a per-tile one-time-programmable store: load of
  the security configuration at power-up, boot-copy stream, gating of
  debug, link and sync paths, and programming through three I/O ports.
  Assumes the core clock and power-up reset of the processor, and that
  the core drives one I/O write or read per cycle on io_req.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otpsec_defs.svh"

// Notes on behaviour
// - Four lockable sectors of 512 32-bit rows
// - Load security config from store at power-up
// - Copy remaining content to SRAM before code
// - Bit 0 blocks JTAG tile state access
// - Bit 1 refuses other tiles via switch
// - Bit 5 boots from store address zero
// - Bit 7 enables redundant rows
// - Bits 8-11 lock programming per sector
// - Bit 12 refuses all programming
// - Bit 13 denies JTAG store read and write
// - Bit 14 disables debug sync pin
// - Bits 21:15 software-readable general field
// - Bits 31:22 extend JTAG user code
// - Address port 16-bit, id 0x100200
// - Data port 32-bit, id 0x200100
// - Control port 16-bit, id 0x100300
// - User code top from bits 22-31
module otpsec_ctrl #(
  parameter int SECTORS = `OTPSEC_SECTORS,
  parameter int ROWS    = `OTPSEC_ROWS
) (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire otpsec_pkg::otpsec_io_t io_req,
  output logic [31:0]               io_rdata,
  output logic                      io_ack,
  output logic                      io_refused,
  input  wire logic                 jtag_tile_req,
  output logic                      jtag_tile_grant,
  input  wire logic                 jtag_otp_req,
  input  wire logic                 jtag_otp_wr,
  input  wire logic [12:0]          jtag_otp_addr,
  input  wire logic [31:0]          jtag_otp_wdata,
  output logic                      jtag_otp_grant,
  output logic [31:0]               jtag_otp_rdata,
  input  wire logic                 link_req,
  output logic                      link_grant,
  input  wire logic                 dbg_sync_in,
  output logic                      dbg_sync_seen,
  input  wire logic                 dbg_sync_drive,
  output logic                      dbg_sync_oe,
  output logic                      dbg_sync_out,
  output logic                      boot_valid,
  output logic [12:0]               boot_addr,
  output logic [31:0]               boot_data,
  output logic                      boot_done,
  output logic                      boot_from_otp,
  output logic                      redund_en,
  output logic [9:0]                jtag_user_code_top,
  output logic [31:0]               security_config_rd
);

  localparam int AW = $clog2(SECTORS * ROWS);

  initial begin
    if (SECTORS != `OTPSEC_SECTORS || ROWS < 2 || (ROWS & (ROWS - 1)) != 0)
      $error("otpsec_ctrl: unsupported store geometry");
  end

  // ==========================================================
  // Store and state
  logic [31:0]              store [SECTORS*ROWS];
  logic [31:0]              security_config;
  logic [15:0]              addr_port;
  logic [15:0]              ctrl_port;
  otpsec_pkg::otpsec_state_t state;
  otpsec_pkg::otpsec_state_t next_state;
  logic [AW-1:0]            copy_ptr;

  // ==========================================================
  // Decode
  wire             wr_addr  = io_req.wr && running && io_req.rid == `OTPSEC_RID_ADDR;
  wire             wr_data  = io_req.wr && io_req.rid == `OTPSEC_RID_DATA;
  wire             wr_ctrl  = io_req.wr && running && io_req.rid == `OTPSEC_RID_CTRL;
  wire             known    = io_req.rid == `OTPSEC_RID_ADDR ||
                              io_req.rid == `OTPSEC_RID_DATA ||
                              io_req.rid == `OTPSEC_RID_CTRL;
  wire             running  = state == otpsec_pkg::OTPSEC_RUN;
  wire [1:0]       sector   = addr_port[AW-1 -: 2];
  wire             mlock    = security_config[`OTPSEC_B_MLOCK];
  wire             slock    = security_config[`OTPSEC_B_SLOCK0 + sector];
  wire             prog_go  = wr_data && running && ctrl_port[`OTPSEC_CTL_PROG];
  wire             cfg_go   = prog_go && ctrl_port[`OTPSEC_CTL_CFG];
  wire             row_ok   = prog_go && !ctrl_port[`OTPSEC_CTL_CFG] && !mlock && !slock;
  wire             cfg_ok   = cfg_go && !mlock;
  wire             refuse   = prog_go && !row_ok && !cfg_ok;
  wire             jo_allow = running && !security_config[`OTPSEC_B_NO_JTAG_OTP];
  wire [1:0]       jo_sect  = jtag_otp_addr[AW-1 -: 2];
  wire             jo_wr_ok = jo_allow && jtag_otp_req && jtag_otp_wr && !mlock &&
                              !security_config[`OTPSEC_B_SLOCK0 + jo_sect];
  // OTP bits only go 0 to 1: new value is OR of old and written
  wire [31:0]      cfg_new  = security_config | io_req.data;
  wire             boot_end = copy_ptr == AW'(SECTORS * ROWS - 2);

  // ==========================================================
  // Power-up sequence
  always_comb begin
    next_state = state;
    unique case (state)
      otpsec_pkg::OTPSEC_LOAD_CFG:  next_state = otpsec_pkg::OTPSEC_COPY_BOOT;
      otpsec_pkg::OTPSEC_COPY_BOOT: if (boot_end) next_state = otpsec_pkg::OTPSEC_RUN;
      otpsec_pkg::OTPSEC_RUN:       next_state = state;
      default:                      next_state = otpsec_pkg::OTPSEC_LOAD_CFG;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) state <= otpsec_pkg::OTPSEC_LOAD_CFG;
    else       state <= next_state;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || state != otpsec_pkg::OTPSEC_COPY_BOOT) copy_ptr <= '0;
    else if (!boot_end)                                copy_ptr <= copy_ptr + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      boot_valid <= 1'b0;
      boot_addr  <= 13'h0000;
      boot_data  <= 32'h0000_0000;
      boot_done  <= 1'b0;
    end else begin
      boot_valid <= state == otpsec_pkg::OTPSEC_COPY_BOOT;
      boot_addr  <= 13'(copy_ptr);
      boot_data  <= store[copy_ptr];
      boot_done  <= running;
    end
  end

  // ==========================================================
  // Security configuration
  always_ff @(posedge core_clk) begin
    if (!nrst)
      security_config <= `OTPSEC_CFG_RESET;
    else if (state == otpsec_pkg::OTPSEC_LOAD_CFG)
      security_config <= store[SECTORS*ROWS-1];
    else if (cfg_ok)
      security_config <= cfg_new;
  end

  // ==========================================================
  // Programming ports and array
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      addr_port <= 16'h0000;
      ctrl_port <= 16'h0000;
    end else begin
      if (wr_addr) addr_port <= io_req.data[15:0];
      if (wr_ctrl) ctrl_port <= io_req.data[15:0];
    end
  end

  // Unprogrammed fuses read as zero
  initial begin
    for (int i = 0; i < SECTORS*ROWS; i++) store[i] = 32'h0000_0000;
  end

  always @(posedge core_clk) begin
    if (row_ok)
      store[addr_port[AW-1:0]] <= store[addr_port[AW-1:0]] | io_req.data;
    else if (cfg_ok)
      store[SECTORS*ROWS-1] <= store[SECTORS*ROWS-1] | io_req.data;
    else if (jo_wr_ok)
      store[jtag_otp_addr[AW-1:0]] <= store[jtag_otp_addr[AW-1:0]] | jtag_otp_wdata;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      io_rdata       <= 32'h0000_0000;
      io_ack         <= 1'b0;
      io_refused     <= 1'b0;
      jtag_otp_rdata <= 32'h0000_0000;
    end else begin
      io_ack         <= io_req.wr && known && running;
      io_refused     <= refuse;
      io_rdata       <= ctrl_port[`OTPSEC_CTL_CFG] ? security_config
                                                   : store[addr_port[AW-1:0]];
      jtag_otp_rdata <= (jo_allow && jtag_otp_req && !jtag_otp_wr)
                        ? store[jtag_otp_addr[AW-1:0]] : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Gating
  assign jtag_tile_grant    = jtag_tile_req && running &&
                              !security_config[`OTPSEC_B_NO_JTAG];
  assign link_grant         = link_req && running &&
                              !security_config[`OTPSEC_B_NO_LINK];
  assign jtag_otp_grant     = jtag_otp_req && jo_allow;
  assign dbg_sync_seen      = !dbg_sync_in && !security_config[`OTPSEC_B_NO_DBG_SYNC];
  assign dbg_sync_oe        = dbg_sync_drive && !security_config[`OTPSEC_B_NO_DBG_SYNC];
  assign dbg_sync_out       = 1'b0;
  assign boot_from_otp      = security_config[`OTPSEC_B_SEC_BOOT];
  assign redund_en          = security_config[`OTPSEC_B_REDUND];
  assign jtag_user_code_top = security_config[`OTPSEC_UC_HI:`OTPSEC_UC_LO];
  assign security_config_rd = security_config;

endmodule : otpsec_ctrl
`default_nettype wire

//--- test/otpsec_chk.sv
/* Port checker for otpsec_ctrl: gates, config fields, acks, boot end.
   Assumes a bind into every otpsec_ctrl instance. */
`timescale 1ns/1ps
`default_nettype none
`include "otpsec_defs.svh"
module otpsec_chk (
  input wire logic                   core_clk,
  input wire logic                   nrst,
  input wire otpsec_pkg::otpsec_io_t io_req,
  input wire logic                   io_ack,
  input wire logic                   jtag_tile_req,
  input wire logic                   jtag_tile_grant,
  input wire logic                   jtag_otp_req,
  input wire logic                   jtag_otp_grant,
  input wire logic                   link_req,
  input wire logic                   link_grant,
  input wire logic                   dbg_sync_drive,
  input wire logic                   dbg_sync_oe,
  input wire logic                   boot_valid,
  input wire logic [12:0]            boot_addr,
  input wire logic                   boot_done,
  input wire logic                   boot_from_otp,
  input wire logic [9:0]             jtag_user_code_top,
  input wire logic [31:0]            security_config_rd
);
  // ====
  // Assertions
  wire logic known = io_req.wr && (io_req.rid == `OTPSEC_RID_ADDR ||
                                   io_req.rid == `OTPSEC_RID_CTRL);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_last_row;
    boot_valid && boot_addr == 13'h7fe;
  endsequence
  a_jtag_gate: assert property (jtag_tile_grant |-> jtag_tile_req && !security_config_rd[0])
    else $error("jtag tile grant while blocked");
  a_link_gate: assert property (link_grant |-> link_req && !security_config_rd[1])
    else $error("link grant while blocked");
  a_jotp_gate: assert property (jtag_otp_grant |-> jtag_otp_req && !security_config_rd[13])
    else $error("jtag store grant while blocked");
  a_sync_gate: assert property (dbg_sync_oe |-> dbg_sync_drive && !security_config_rd[14])
    else $error("sync pin driven while disabled");
  a_boot_src: assert property (boot_from_otp === security_config_rd[5])
    else $error("boot source differs from config");
  a_user_code: assert property (jtag_user_code_top === security_config_rd[31:22])
    else $error("user code field differs");
  a_ack_known: assert property (boot_done && known |=> io_ack)
    else $error("port write not acknowledged");
  a_boot_end: assert property (s_last_row |=> boot_done && !boot_valid)
    else $error("copy did not end after last row");
endmodule : otpsec_chk
bind otpsec_ctrl otpsec_chk otpsec_chk_inst (.core_clk, .nrst, .io_req, .io_ack,
  .jtag_tile_req, .jtag_tile_grant, .jtag_otp_req, .jtag_otp_grant, .link_req,
  .link_grant, .dbg_sync_drive, .dbg_sync_oe, .boot_valid, .boot_addr, .boot_done,
  .boot_from_otp, .jtag_user_code_top, .security_config_rd);
`default_nettype wire

//--- test/tb_top.sv
/* Bench for otpsec_ctrl: reset, boot copy, port writes, gate traffic.
   Assumes the design and its bound checker compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "otpsec_defs.svh"
module tb_top;
  logic core_clk, nrst, jtag_tile_req, jtag_otp_req, jtag_otp_wr, link_req;
  logic dbg_sync_in, dbg_sync_drive, io_ack, io_refused, jtag_tile_grant, jtag_otp_grant;
  logic link_grant, dbg_sync_seen, dbg_sync_oe, dbg_sync_out, boot_valid, boot_done;
  logic boot_from_otp, redund_en;
  logic [12:0] jtag_otp_addr, boot_addr, first;
  logic [31:0] jtag_otp_wdata, io_rdata, jtag_otp_rdata, boot_data, security_config_rd;
  logic [9:0]  jtag_user_code_top;
  otpsec_pkg::otpsec_io_t io_req;
  int errors, checked, cycles, rows;
  localparam logic [31:0] CFG_VAL = 32'haa8a_e1a3;
  otpsec_ctrl otpsec_ctrl_inst (.core_clk, .nrst, .io_req, .io_rdata, .io_ack, .io_refused,
    .jtag_tile_req, .jtag_tile_grant, .jtag_otp_req, .jtag_otp_wr, .jtag_otp_addr,
    .jtag_otp_wdata, .jtag_otp_grant, .jtag_otp_rdata, .link_req, .link_grant,
    .dbg_sync_in, .dbg_sync_seen, .dbg_sync_drive, .dbg_sync_oe, .dbg_sync_out,
    .boot_valid, .boot_addr, .boot_data, .boot_done, .boot_from_otp, .redund_en,
    .jtag_user_code_top, .security_config_rd);
  // ====
  // Clock, timeout, copy counter
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    cycles++;
    if (nrst && boot_valid === 1'b1) begin
      if (rows == 0) first = boot_addr;
      rows++;
    end
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  // ====
  // Tasks
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic io_wr(logic [23:0] rid, logic [31:0] data, logic ack, logic refused);
    io_req = '{1'b1, rid, data};
    @(negedge core_clk);
    io_req.wr = 1'b0;
    check("io_ack", {31'h0, io_ack}, {31'h0, ack});
    check("io_refused", {31'h0, io_refused}, {31'h0, refused});
    @(negedge core_clk);
  endtask : io_wr
  task automatic print_verdict();
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ====
  // Sequence: two boots, second one after a reset in mid-run
  initial begin
    {nrst, jtag_tile_req, jtag_otp_req, jtag_otp_wr, link_req, dbg_sync_drive} = '0;
    {io_req, jtag_otp_addr, jtag_otp_wdata} = '0;
    dbg_sync_in = 1'b1;
    {errors, checked, cycles, rows} = '0;
    for (int pass = 0; pass < 2; pass++) begin
      nrst = 1'b0;
      repeat (12) @(negedge core_clk);
      check("boot_valid", {31'h0, boot_valid}, 32'h0);
      check("boot_done", {31'h0, boot_done}, 32'h0);
      rows = 0;
      nrst = 1'b1;
      io_wr(`OTPSEC_RID_CTRL, 32'h0, 1'b0, 1'b0);
      for (int i = 0; i < 3000 && boot_done !== 1'b1; i++) @(negedge core_clk);
      check("copied rows", rows, 32'd2047);
      check("first row", {19'h0, first}, 32'h0);
      check("boot_valid", {31'h0, boot_valid}, 32'h0);
      check("config", security_config_rd, pass ? CFG_VAL : 32'h0);
      check("user code", {22'h0, jtag_user_code_top}, pass ? 32'h2aa : 32'h0);
      check("boot src", {31'h0, boot_from_otp}, {31'h0, pass[0]});
      check("redund", {31'h0, redund_en}, {31'h0, pass[0]});
      {jtag_tile_req, jtag_otp_req, link_req, dbg_sync_drive, dbg_sync_in} = 5'b11110;
      @(negedge core_clk);
      check("tile grant", {31'h0, jtag_tile_grant}, {31'h0, !pass[0]});
      check("link grant", {31'h0, link_grant}, {31'h0, !pass[0]});
      check("otp grant", {31'h0, jtag_otp_grant}, {31'h0, !pass[0]});
      check("otp rdata", jtag_otp_rdata, 32'h0);
      check("sync oe", {31'h0, dbg_sync_oe}, {31'h0, !pass[0]});
      check("sync seen", {31'h0, dbg_sync_seen}, {31'h0, !pass[0]});
      {jtag_tile_req, jtag_otp_req, link_req, dbg_sync_drive, dbg_sync_in} = 5'b00001;
      io_wr(`OTPSEC_RID_ADDR, 32'h0, 1'b1, 1'b0);
      io_wr(`OTPSEC_RID_CTRL, 32'h1, 1'b1, 1'b0);
      io_wr(`OTPSEC_RID_DATA, 32'ha5, 1'b1, pass[0]);
      io_wr(`OTPSEC_RID_CTRL, 32'h0, 1'b1, 1'b0);
      check("row read", io_rdata, 32'ha5);
      io_wr(`OTPSEC_RID_CTRL, 32'h3, 1'b1, 1'b0);
      io_wr(`OTPSEC_RID_DATA, CFG_VAL, 1'b1, 1'b0);
      io_wr(`OTPSEC_RID_DATA, 32'h0, 1'b1, 1'b0);
      check("config kept", security_config_rd, CFG_VAL);
      check("gp field", {25'h0, security_config_rd[21:15]}, 32'h15);
      check("user code", {22'h0, jtag_user_code_top}, 32'h2aa);
      if (pass == 1) begin
        io_wr(`OTPSEC_RID_DATA, 32'h1000, 1'b1, 1'b0);
        io_wr(`OTPSEC_RID_ADDR, 32'h200, 1'b1, 1'b0);
        io_wr(`OTPSEC_RID_CTRL, 32'h1, 1'b1, 1'b0);
        io_wr(`OTPSEC_RID_DATA, 32'h1, 1'b1, 1'b1);
      end
      io_wr(24'h100201, 32'h0, 1'b0, 1'b0);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
